// >>> design/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// Register offsets (byte addresses on the card's PCI window)
`define OFF_INTERRUPT_FLAGS    8'h08
`define OFF_SEQUENCER_CONTROL  8'h0a
`define OFF_SEQUENCER_FLAGS    8'h0c
`define OFF_SEQUENCE_PERIOD    8'h0e
`define OFF_IRAM_BASE          8'h80
`define OFF_IRAM_LAST          8'hbe

// Field positions
`define IF_CONV_READY          0
`define IF_SETTLING_READY      1
`define IF_SEQ_PENDING         2
`define SC_RUN                 0
`define SC_IRQ_ENABLE          1
`define SF_AVAILABLE           0
`define SF_OVERFLOW            1
`define SF_TIMER_ERROR         2
`define SF_IRAM_ERROR          3
`define CC_AUTO_SETTLE         8
`define CC_IRQ_ENABLE          10
`define INSTR_ENABLE           3

// Reset values
`define RST_SEQUENCE_PERIOD    16'h0000

// Timing
`define CLK_PERIOD_NS          10
`define TICK_PERIOD_NS         100000
`define TICK_CYCLES            (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define STEP_CYCLES_DEFAULT    16'h0010

`endif

// >>> design/adc_seq_pkg.sv
package adc_seq_pkg;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_STEP, SEQ_WAIT} seq_state_t;
  typedef logic [15:0] word_t;
endpackage : adc_seq_pkg

// >>> design/adc_sequencer_interrupt_control.sv
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module adc_sequencer_interrupt_control (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  input  wire logic                 clk_en,
  // Register port
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  input  wire logic [7:0]           reg_addr,
  input  wire adc_seq_pkg::word_t   reg_wdata,
  output adc_seq_pkg::word_t        reg_rdata,
  // Converter side
  input  wire logic [15:0]          conversion_control,
  input  wire logic                 settle_done,
  input  wire logic                 conversion_done,
  input  wire logic                 convert_write,
  output logic                      convert_start,
  // Sequencer step output
  output logic                      step_start,
  output logic [4:0]                step_channel,
  output logic [2:0]                step_gain,
  output logic                      results_commit,
  output logic                      sequencer_busy,
  // Interrupt request to PCI
  output logic                      irq
);
  import adc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [1:0]  ready_flags;
  logic [1:0]  sequencer_control;
  logic [3:0]  sequencer_flags;
  word_t       sequence_period;
  logic [3:0]  instruction_ram [32];
  logic [15:0] period_count;
  logic [15:0] step_count;
  logic [4:0]  channel;
  logic        any_enabled;
  seq_state_t  state;
  logic        tick;
  logic        seq_start;
  logic        step_hold;
  logic [4:0]  next_channel;
  logic [3:0]  visible_flags;
  logic        timer_expire;
  logic        continuous;
  logic        iram_error_set;
  logic        sequencer_pending;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic w1c(input logic wr, input logic [7:0] a, input logic [7:0] off,
                               input logic b);
    w1c = wr && hit(a, off) && b;
  endfunction : w1c

  function automatic logic in_iram(input logic [7:0] a);
    in_iram = (a >= `OFF_IRAM_BASE) && (a <= `OFF_IRAM_LAST);
  endfunction : in_iram

  // Continuous mode hides timer and overflow errors from software and the irq alike
  function automatic logic [3:0] shown(input logic [3:0] f, input logic cont);
    shown = {f[`SF_IRAM_ERROR], f[`SF_TIMER_ERROR] && !cont, f[`SF_OVERFLOW] && !cont,
             f[`SF_AVAILABLE]};
  endfunction : shown

  assign continuous    = (sequence_period == 16'h0000);
  assign visible_flags = shown(sequencer_flags, continuous);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt flags

  // Set wins over a simultaneous clear so no event is lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_flags <= 2'h0;
    end else if (clk_en) begin
      for (int i = `IF_CONV_READY; i <= `IF_SETTLING_READY; i++) begin
        if (w1c(reg_write, reg_addr, `OFF_INTERRUPT_FLAGS, reg_wdata[i])) begin
          ready_flags[i] <= 1'b0;
        end
      end
      if (settle_done && conversion_control[`CC_IRQ_ENABLE]
          && !conversion_control[`CC_AUTO_SETTLE]) begin
        ready_flags[`IF_SETTLING_READY] <= 1'b1;
      end
      if (conversion_done && conversion_control[`CC_IRQ_ENABLE]) begin
        ready_flags[`IF_CONV_READY] <= 1'b1;
      end
    end
  end

  // Derived, never stored, so a write to the interrupt flags cannot clear it
  assign sequencer_pending = sequencer_control[`SC_IRQ_ENABLE]
                             && (|visible_flags[3:1]);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer control, period and instruction RAM

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sequencer_control <= 2'h0;
      sequence_period   <= `RST_SEQUENCE_PERIOD;
    end else if (clk_en && reg_write) begin
      if (hit(reg_addr, `OFF_SEQUENCER_CONTROL)) begin
        sequencer_control <= reg_wdata[1:0];
      end
      if (hit(reg_addr, `OFF_SEQUENCE_PERIOD)) begin
        sequence_period <= reg_wdata;
      end
    end
  end

  // Only enable and gain are kept; upper bits read as zero
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < 32; i++) begin
        instruction_ram[i] <= 4'h0;
      end
    end else if (clk_en && reg_write && in_iram(reg_addr) && !reg_addr[0]) begin
      instruction_ram[reg_addr[5:1]] <= reg_wdata[3:0];
    end
  end

  always_comb begin
    any_enabled = 1'b0;
    for (int i = 0; i < 32; i++) begin
      any_enabled = any_enabled | instruction_ram[i][`INSTR_ENABLE];
    end
  end

  assign convert_start = convert_write && !sequencer_control[`SC_RUN];

  ////////////////////////////////////////////////////////////////////////////
  // Sequence timer

  tick_divider #(
    .CYCLES (`TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .clk_en   (clk_en),
    .restart  (seq_start),
    .tick     (tick)
  );

  // Expiry when the tick count reaches the programmed period
  assign timer_expire = !continuous && tick
                        && (period_count + 16'h0001 == sequence_period);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_count <= 16'h0000;
    end else if (clk_en) begin
      if (seq_start || timer_expire) begin
        period_count <= 16'h0000;
      end else if (tick) begin
        period_count <= period_count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer engine

  // A new pass starts on run, on an expiry while in SEQ_WAIT, or back to back in continuous mode
  logic run_ok;
  assign run_ok = sequencer_control[`SC_RUN] && !(|visible_flags[3:1]);
  assign iram_error_set = run_ok && !any_enabled && state == SEQ_IDLE;
  assign seq_start = run_ok && any_enabled
                     && ((state == SEQ_IDLE && (continuous || !sequencer_busy))
                         || (state == SEQ_WAIT && (continuous || timer_expire)));
  assign next_channel = channel + 5'd1;
  assign step_hold    = (step_count != 16'h0000) && instruction_ram[channel][`INSTR_ENABLE];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state          <= SEQ_IDLE;
      channel        <= 5'd0;
      step_count     <= 16'h0000;
      sequencer_busy <= 1'b0;
      step_start     <= 1'b0;
      results_commit <= 1'b0;
    end else if (clk_en) begin
      step_start     <= 1'b0;
      results_commit <= 1'b0;
      unique case (state)
        SEQ_IDLE, SEQ_WAIT: begin
          if (seq_start) begin
            state          <= SEQ_STEP;
            channel        <= 5'd0;
            step_count     <= `STEP_CYCLES_DEFAULT;
            sequencer_busy <= 1'b1;
            step_start     <= instruction_ram[0][`INSTR_ENABLE];
          end else if (!run_ok) begin
            state          <= SEQ_IDLE;
            sequencer_busy <= 1'b0;
          end else if (state == SEQ_IDLE && !continuous) begin
            state <= SEQ_WAIT;
          end
        end
        SEQ_STEP: begin
          // Disabled channels are walked quickly; only enabled ones take step time
          if (step_hold) begin
            step_count <= step_count - 16'h0001;
          end else if (channel == 5'd31) begin
            results_commit <= 1'b1;
            state          <= SEQ_WAIT;
          end else begin
            channel    <= next_channel;
            step_count <= `STEP_CYCLES_DEFAULT;
            step_start <= instruction_ram[next_channel][`INSTR_ENABLE];
          end
        end
        default: state <= SEQ_IDLE;
      endcase
    end
  end

  assign step_channel = channel;

  // Gain is latched with the channel so a RAM write cannot change a step under way
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      step_gain <= 3'h0;
    end else if (clk_en) begin
      if (seq_start) begin
        step_gain <= instruction_ram[0][2:0];
      end else if (state == SEQ_STEP && !step_hold && channel != 5'd31) begin
        step_gain <= instruction_ram[next_channel][2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer status flags

  logic seq_end;
  assign seq_end = (state == SEQ_STEP) && (channel == 5'd31) && !step_hold;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sequencer_flags <= 4'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 4; i++) begin
        if (w1c(reg_write, reg_addr, `OFF_SEQUENCER_FLAGS, reg_wdata[i])) begin
          sequencer_flags[i] <= 1'b0;
        end
      end
      if (iram_error_set) begin
        sequencer_flags[`SF_IRAM_ERROR] <= 1'b1;
      end
      if (timer_expire && state == SEQ_STEP) begin
        sequencer_flags[`SF_TIMER_ERROR] <= 1'b1;
      end
      if (seq_end) begin
        sequencer_flags[`SF_AVAILABLE] <= 1'b1;
        if (sequencer_flags[`SF_AVAILABLE] && !continuous) begin
          sequencer_flags[`SF_OVERFLOW] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path and interrupt

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (clk_en && reg_read) begin
      if (hit(reg_addr, `OFF_INTERRUPT_FLAGS)) begin
        reg_rdata <= {13'h0000, sequencer_pending, ready_flags[1:0]};
      end else if (hit(reg_addr, `OFF_SEQUENCER_CONTROL)) begin
        reg_rdata <= {14'h0000, sequencer_control};
      end else if (hit(reg_addr, `OFF_SEQUENCER_FLAGS)) begin
        reg_rdata <= {12'h000, visible_flags};
      end else if (hit(reg_addr, `OFF_SEQUENCE_PERIOD)) begin
        reg_rdata <= sequence_period;
      end else if (in_iram(reg_addr)) begin
        reg_rdata <= {12'h000, instruction_ram[reg_addr[5:1]]};
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= sequencer_control[`SC_IRQ_ENABLE] && (|visible_flags);
    end
  end

endmodule : adc_sequencer_interrupt_control

// >>> design/tick_divider.sv
`timescale 1ns/1ns
`include "adc_seq_defines.svh"

module tick_divider #(
  parameter int unsigned CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  // Control
  input  wire logic restart,
  // Tick
  output logic      tick
);
  logic [15:0] count;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 16'h0000;
      tick  <= 1'b0;
    end else if (clk_en) begin
      if (restart || count == 16'(CYCLES - 1)) begin
        count <= 16'h0000;
      end else begin
        count <= count + 16'h0001;
      end
      tick <= !restart && count == 16'(CYCLES - 1);
    end
  end
endmodule : tick_divider

// >>> test/adc_seq_sva.sv
`timescale 1ns/1ns
`include "adc_seq_defines.svh"
module adc_seq_sva (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               reset_n,
  input wire logic               clk_en,
  // Watched ports
  input wire logic               reg_read,
  input wire logic               reg_write,
  input wire logic [7:0]         reg_addr,
  input wire adc_seq_pkg::word_t reg_wdata,
  input wire adc_seq_pkg::word_t reg_rdata,
  input wire logic               convert_write,
  input wire logic               convert_start,
  input wire logic               step_start,
  input wire logic               results_commit,
  input wire logic               sequencer_busy,
  input wire logic               irq
);
  import adc_seq_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Run bit as software last wrote it, rebuilt from the bus alone
  logic run_seen;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_seen <= 1'b0;
    end else if (clk_en && reg_write && reg_addr == `OFF_SEQUENCER_CONTROL) begin
      run_seen <= reg_wdata[`SC_RUN];
    end
  end
  // Steps last sixteen cycles, so eight quiet cycles is a safe floor
  sequence s_gap;
    !step_start [*8];
  endsequence
  sequence s_no_access;
    !reg_write && !$past(reg_write);
  endsequence
  step_gap_a: assert property (step_start |=> s_gap) else $error("step too soon");
  conv_gate_a: assert property (convert_start == (convert_write && !run_seen))
    else $error("bad start");
  commit_busy_a: assert property (results_commit |-> $past(sequencer_busy))
    else $error("commit while idle");
  commit_pulse_a: assert property (results_commit |=> !results_commit) else $error("long commit");
  // Disabled channels take one cycle each, so the first enabled step is at most 31 away
  busy_start_a: assert property ($rose(sequencer_busy) |-> ##[0:31] step_start)
    else $error("busy without step");
  irq_hold_a: assert property ((irq ##0 s_no_access) |=> irq) else $error("irq dropped");
  rdata_hold_a: assert property (!reg_read && !$past(reg_read) |=> $stable(reg_rdata))
    else $error("read data moved");
  // Reset must be checked while it is active, so no disable here
  reset_quiet_a: assert property (@(posedge core_clk) disable iff (1'b0)
    !reset_n |-> !irq && !step_start && !sequencer_busy) else $error("active in reset");
endmodule : adc_seq_sva
bind adc_sequencer_interrupt_control adc_seq_sva adc_seq_sva_i (.core_clk(core_clk),
  .reset_n(reset_n), .clk_en(clk_en), .reg_read(reg_read), .reg_write(reg_write),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .convert_write(convert_write), .convert_start(convert_start), .step_start(step_start),
  .results_commit(results_commit), .sequencer_busy(sequencer_busy), .irq(irq));

// >>> test/converter_model.sv
`timescale 1ns/1ns
module converter_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic reset_n,
  // Requests
  input  wire logic settle_req,
  input  wire logic convert_start,
  // Completions
  output logic      settle_done,
  output logic      conversion_done
);
  logic [3:0] conv_pipe;
  // A fixed four-cycle conversion keeps the flag timing easy to predict
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_pipe <= 4'h0;
      settle_done <= 1'b0;
    end else begin
      conv_pipe <= {conv_pipe[2:0], convert_start};
      settle_done <= settle_req;
    end
  end
  assign conversion_done = conv_pipe[3];
endmodule : converter_model

// >>> test/tb_adc_sequencer_interrupt_control.sv
`timescale 1ns/1ns
module tb_adc_sequencer_interrupt_control;
  import adc_seq_pkg::*;
  typedef struct {logic [7:0] a; word_t w; word_t r;} row_t;
  logic       core_clk, reset_n, reg_write, reg_read, convert_write, settle_req;
  logic       settle_done, conversion_done, convert_start, step_start, results_commit;
  logic       busy, irq;
  logic [7:0] reg_addr;
  logic [4:0] chan;
  logic [2:0] gain;
  word_t      reg_wdata, reg_rdata, cctl, rd;
  int         n_errors, total_checks, c;
  row_t rows [7] = '{'{8'h0e, 16'hffff, 16'hffff}, '{8'h0e, 16'h0001, 16'h0001},
    '{8'h0a, 16'h0002, 16'h0002}, '{8'h08, 16'h0004, 16'h0000},
    '{8'h0c, 16'h000f, 16'h0000}, '{8'h20, 16'h5a5a, 16'h0000},
    '{8'hbe, 16'hfff5, 16'h0005}};
  ////////////////////////////////////////////////////////////////////////////////
  adc_sequencer_interrupt_control adc_sequencer_interrupt_control_i (.core_clk(core_clk),
    .reset_n(reset_n), .clk_en(1'b1), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .conversion_control(cctl), .settle_done(settle_done), .conversion_done(conversion_done),
    .convert_write(convert_write), .convert_start(convert_start), .step_start(step_start),
    .step_channel(chan), .step_gain(gain), .results_commit(results_commit), .sequencer_busy(busy),
    .irq(irq));
  converter_model converter_model_i (.core_clk(core_clk), .reset_n(reset_n),
    .settle_req(settle_req), .convert_start(convert_start), .settle_done(settle_done),
    .conversion_done(conversion_done));
  ////////////////////////////////////////////////////////////////////////////////
  task report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task check(input word_t seen, input word_t exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] a, input word_t w);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = w;
    reg_write = 1'b1;
    @(negedge core_clk);
    reg_write = 1'b0;
  endtask : wr
  task rdr(input logic [7:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_read = 1'b1;
    @(negedge core_clk);
    reg_read = 1'b0;
    @(negedge core_clk);
    rd = reg_rdata;
  endtask : rdr
  task kick(input logic s);
    @(negedge core_clk);
    if (s) settle_req = 1'b1;
    else convert_write = 1'b1;
    @(negedge core_clk);
    settle_req = 1'b0;
    convert_write = 1'b0;
    repeat (6) @(negedge core_clk);
  endtask : kick
  // Every wait is bounded so a stuck sequencer ends the run
  task wait_sig(input bit sel, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(posedge core_clk);
      #1;
      if (sel ? busy === 1'b0 : results_commit === 1'b1) return;
    end
    n_errors++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  endtask : wait_sig
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    {reset_n, reg_write, reg_read, convert_write, settle_req} = 5'h00;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    cctl = 16'h0400;
    n_errors = 0;
    total_checks = 0;
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdr(8'h08 + 8'(2 * i));
      check(rd, 16'h0000);
    end
    $display("reset values done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rdr(rows[i].a);
      check(rd, rows[i].r);
    end
    wr(8'h0a, 16'h0000);
    wr(8'h0e, 16'h0000);
    $display("register rows done");
    kick(1'b0);
    rdr(8'h08);
    check(rd, 16'h0001);
    wr(8'h08, 16'h0000);
    rdr(8'h08);
    check(rd, 16'h0001);
    kick(1'b1);
    rdr(8'h08);
    check(rd, 16'h0003);
    wr(8'h08, 16'h0003);
    rdr(8'h08);
    check(rd, 16'h0000);
    cctl = 16'h0500;
    kick(1'b1);
    rdr(8'h08);
    check(rd, 16'h0000);
    cctl = 16'h0000;
    kick(1'b0);
    rdr(8'h08);
    check(rd, 16'h0000);
    $display("ready flags done");
    wr(8'h0a, 16'h0003);
    rdr(8'h0c);
    check(rd, 16'h0008);
    rdr(8'h08);
    check(rd, 16'h0004);
    check(word_t'(irq), 16'h0001);
    wr(8'h0a, 16'h0000);
    wr(8'h0c, 16'h0008);
    rdr(8'h08);
    check(rd, 16'h0000);
    check(word_t'(irq), 16'h0000);
    $display("empty program done");
    wr(8'h80, 16'h0008);
    wr(8'h0a, 16'h0003);
    @(negedge core_clk);
    convert_write = 1'b1;
    #1;
    check(word_t'(convert_start), 16'h0000);
    @(negedge core_clk);
    convert_write = 1'b0;
    wait_sig(1'b0, 200);
    check(word_t'(chan), 16'h001f);
    check(word_t'(gain), 16'h0005);
    wait_sig(1'b0, 200);
    rdr(8'h0c);
    check(rd, 16'h0001);
    wr(8'h0a, 16'h0000);
    wait_sig(1'b1, 200);
    wr(8'h0c, 16'h0001);
    rdr(8'h0c);
    check(rd, 16'h0000);
    $display("continuous mode done");
    wr(8'h0e, 16'h0002);
    wr(8'h0a, 16'h0001);
    wait_sig(1'b0, 21000);
    wait_sig(1'b0, 21000);
    rdr(8'h0c);
    check(rd, 16'h0003);
    c = 0;
    repeat (21000) begin
      @(posedge core_clk);
      #1;
      if (results_commit === 1'b1) c++;
    end
    check(word_t'(c), 16'h0000);
    $display("timed mode done");
    @(negedge core_clk);
    reset_n = 1'b0;
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    rdr(8'h0c);
    check(rd, 16'h0000);
    rdr(8'h0e);
    check(rd, 16'h0000);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule : tb_adc_sequencer_interrupt_control
